// File: hdl/omsc_mode_ctrl.sv
// Behaviour
// - Stop bit seven write enters stop.
// - Stop halts both oscillators and operation.
// - Stop holds state; port hold bit governs outputs.
// - Stop entry clears prescaler and divider.
// - Held program counter is start plus two.
// - Wake pin, key wakeup, voltage detect release.
// - Resets end stop, warm up, run single.
// - Release select: one level, zero edge.
// - Level mode releases on high wake pin.
// - Level mode refuses stop while pin high.
// - Warm-up source follows clock before stop.
// - Pin low during warm-up no re-entry.
// - Edge mode releases on rising pin edge.
// - Edge mode enters stop with pin high.
// - Edge within one machine cycle ignored.
// - Wake pin shared with port and interrupt.
// - Dual run: CPU fast, watchdog either clock.
// - Slow modes: machine cycle four slow periods.
// - Timebase idle released by falling source edge.
// - Idle bit halts CPU; pending interrupt releases.
// - Halt bit gates all but timebase timer.
// - Wake release returns to prior mode.
// - Return to slow_hf_off keeps fast oscillator off.
`timescale 1ns/1ps
module omsc_mode_ctrl
	import omsc_pkg::*;
#(
	parameter logic [CNT_W-1:0] RESET_WARMUP = RST_WARMUP
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Software writes and settings
	input wire logic sysctl_one_wr,
	input wire logic [7:0] sysctl_one_wdata,
	input wire logic sysctl_two_wr,
	input wire logic [7:0] sysctl_two_wdata,
	input wire logic [CNT_W-1:0] warmup_count_reg,
	input wire logic [TBT_SEL_W-1:0] timebase_source_select,
	input wire logic wdt_low_select,
	input wire logic int_latch_pending,
	input wire logic [PC_W-1:0] stop_instr_pc,
	// Clock ticks
	input wire logic high_freq_tick,
	input wire logic low_freq_tick,
	input wire logic [TBT_SRC_N-1:0] tbt_src_clocks,
	// Wake and reset sources
	input wire logic stop_pin_n,
	input wire logic key_wakeup,
	input wire logic volt_detect_wake,
	input wire logic sys_reset_req,
	// Register readback
	output logic [7:0] sysctl_one_rd,
	output logic [7:0] sysctl_two_rd,
	output omsc_mode_type op_mode,
	output logic [PC_W-1:0] held_pc,
	// Clock and gating controls
	output logic hf_osc_en,
	output logic lf_osc_en,
	output logic cpu_clk_en,
	output logic wdt_clk_en,
	output logic wdt_low_src,
	output logic periph_clk_en,
	output logic tbt_clk_en,
	output logic mc_low_freq,
	output logic tg_clear,
	output logic core_hold,
	output logic port_output_enable,
	output logic warmup_active,
	// Shared pin fan-out
	output logic port1_bit1_in,
	output logic ext_interrupt_five_n
);

	typedef struct packed {
		omsc_mode_type state;
		omsc_mode_type saved;
		logic [7:0] s1;
		logic [7:0] s2;
		logic [PC_W-1:0] pc;
		logic [1:0] lf_div;
		logic tbt_prev;
		logic to_reset;
		logic wu_start;
		logic arm;
		logic tg_clear;
	} omsc_main_st_type;

	localparam omsc_main_st_type MAIN_RST = '{
		state: warmup_mode,
		saved: run_single_clock,
		s1: S1_RST,
		s2: S2_RST,
		pc: '0,
		lf_div: 2'h0,
		tbt_prev: 1'b0,
		to_reset: 1'b1,
		wu_start: 1'b1,
		arm: 1'b0,
		tg_clear: 1'b0
	};

	omsc_main_st_type main_reg;
	omsc_main_st_type main_next;
	omsc_ctl_if ctl();
	omsc_mode_type target;
	logic tbt_cur;
	logic tbt_fall;
	logic any_wake;
	logic frozen;

	// ----------------------------------------
	// Mode classes
	// ----------------------------------------
	function automatic logic is_slow(input omsc_mode_type m);
		is_slow = (m == slow_hf_on) || (m == slow_hf_off) ||
			(m == timebase_only_idle_slow) || (m == core_idle_slow);
	endfunction

	function automatic logic is_run(input omsc_mode_type m);
		is_run = (m == run_single_clock) || (m == run_dual_clock) ||
			(m == slow_hf_on) || (m == slow_hf_off);
	endfunction

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	omsc_wake_detect u_wake (
		.core_clk(core_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.ctl(ctl)
	);

	omsc_warmup u_warm (
		.core_clk(core_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.ctl(ctl)
	);

	assign target = main_reg.to_reset ? run_single_clock : main_reg.saved;
	assign tbt_cur = tbt_src_clocks[timebase_source_select];
	assign tbt_fall = main_reg.tbt_prev & ~tbt_cur;
	assign any_wake = ctl.wake_release | key_wakeup | volt_detect_wake;
	assign frozen = (main_reg.state == stop_mode) || (main_reg.state == warmup_mode);

	assign ctl.wake_arm = main_reg.arm;
	assign ctl.in_stop = (main_reg.state == stop_mode);
	assign ctl.level_mode = main_reg.s1[S1_RELEASE_MODE_SELECT];
	assign ctl.pin_level = stop_pin_n;
	// The guard counts machine cycles of the clock that ran before stop.
	assign ctl.mc_tick = is_slow(main_reg.saved) ?
		(low_freq_tick && (main_reg.lf_div == LF_DIV_LAST)) : high_freq_tick;
	assign ctl.wu_start = main_reg.wu_start;
	assign ctl.wu_use_low = ~main_reg.to_reset & is_slow(main_reg.saved);
	assign ctl.wu_count = main_reg.to_reset ? RESET_WARMUP : warmup_count_reg;
	assign ctl.hf_tick = high_freq_tick;
	assign ctl.lf_tick = low_freq_tick;

	// ----------------------------------------
	// Mode sequencing
	// ----------------------------------------
	always_comb
	begin
		main_next = main_reg;
		main_next.wu_start = 1'b0;
		main_next.arm = 1'b0;
		main_next.tg_clear = 1'b0;
		main_next.tbt_prev = tbt_cur;
		if (low_freq_tick)
		begin
			main_next.lf_div = 2'(main_reg.lf_div + 2'h1);
		end
		if (sys_reset_req)
		begin
			main_next = MAIN_RST;
			main_next.tbt_prev = tbt_cur;
		end
		else
		begin
			case (main_reg.state)
				run_single_clock, run_dual_clock, slow_hf_on, slow_hf_off:
				begin
					if (sysctl_two_wr)
					begin
						main_next.s2 = sysctl_two_wdata;
						main_next.s2[S2_IDLE] = 1'b0;
						main_next.s2[S2_TIMING_GEN_HALT_BIT] = 1'b0;
					end
					if (sysctl_one_wr)
					begin
						main_next.s1 = sysctl_one_wdata;
						main_next.s1[S1_STOP] = 1'b0;
						// A refused start leaves the stop bit reading zero.
						if (sysctl_one_wdata[S1_STOP] &&
							!(sysctl_one_wdata[S1_RELEASE_MODE_SELECT] && stop_pin_n))
						begin
							main_next.s1[S1_STOP] = 1'b1;
							main_next.state = stop_mode;
							main_next.saved = main_reg.state;
							main_next.pc = PC_W'(stop_instr_pc + PC_STEP);
							main_next.lf_div = 2'h0;
							main_next.tg_clear = 1'b1;
							main_next.arm = 1'b1;
						end
					end
					else if (sysctl_two_wr && sysctl_two_wdata[S2_IDLE])
					begin
						// A pending latch cancels the start; the idle bit stays clear.
						if (!int_latch_pending)
						begin
							main_next.s2[S2_IDLE] = 1'b1;
							main_next.saved = main_reg.state;
							main_next.pc = PC_W'(stop_instr_pc + PC_STEP);
							if (main_reg.state == run_single_clock)
							begin
								main_next.state = core_idle_single;
							end
							else if (main_reg.state == run_dual_clock)
							begin
								main_next.state = core_idle_dual;
							end
							else
							begin
								main_next.state = core_idle_slow;
							end
						end
					end
					else if (sysctl_two_wr && sysctl_two_wdata[S2_TIMING_GEN_HALT_BIT])
					begin
						main_next.s2[S2_TIMING_GEN_HALT_BIT] = 1'b1;
						main_next.saved = main_reg.state;
						main_next.pc = PC_W'(stop_instr_pc + PC_STEP);
						main_next.state = is_slow(main_reg.state) ?
							timebase_only_idle_slow : timebase_only_idle_fast;
					end
					else if (main_reg.state == run_single_clock)
					begin
						if (main_reg.s2[S2_XTEN])
						begin
							main_next.state = run_dual_clock;
						end
					end
					else if (main_reg.state == run_dual_clock)
					begin
						if (!main_reg.s2[S2_XTEN])
						begin
							main_next.state = run_single_clock;
						end
						else if (main_reg.s2[S2_SYSCK])
						begin
							main_next.state = slow_hf_on;
						end
					end
					else if (main_reg.state == slow_hf_on)
					begin
						if (!main_reg.s2[S2_SYSCK])
						begin
							main_next.state = run_dual_clock;
						end
						else if (!main_reg.s2[S2_XEN])
						begin
							main_next.state = slow_hf_off;
						end
					end
					else if (main_reg.s2[S2_XEN])
					begin
						main_next.state = slow_hf_on;
					end
				end
				core_idle_single, core_idle_dual, core_idle_slow:
				begin
					if (int_latch_pending)
					begin
						main_next.state = main_reg.saved;
						main_next.s2[S2_IDLE] = 1'b0;
					end
				end
				timebase_only_idle_fast, timebase_only_idle_slow:
				begin
					if (tbt_fall)
					begin
						main_next.state = main_reg.saved;
						main_next.s2[S2_TIMING_GEN_HALT_BIT] = 1'b0;
					end
				end
				stop_mode:
				begin
					if (any_wake)
					begin
						main_next.state = warmup_mode;
						main_next.wu_start = 1'b1;
						main_next.to_reset = 1'b0;
					end
				end
				warmup_mode:
				begin
					// The wake pin is not looked at here, so it cannot restart stop.
					if (ctl.wu_done)
					begin
						main_next.state = target;
						main_next.s1[S1_STOP] = 1'b0;
						main_next.tg_clear = 1'b1;
						main_next.to_reset = 1'b0;
					end
				end
				default:
				begin
					main_next = MAIN_RST;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			main_reg <= MAIN_RST;
		end
		else if (clk_en)
		begin
			main_reg <= main_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sysctl_one_rd = main_reg.s1;
	assign sysctl_two_rd = main_reg.s2;
	assign op_mode = main_reg.state;
	assign held_pc = main_reg.pc;
	assign tg_clear = main_reg.tg_clear;
	assign warmup_active = (main_reg.state == warmup_mode);

	// While warming up, only the oscillators the return mode needs are started.
	assign hf_osc_en = (main_reg.state != stop_mode) && ((main_reg.state == warmup_mode) ?
		(target != slow_hf_off) : main_reg.s2[S2_XEN]);
	assign lf_osc_en = (main_reg.state != stop_mode) && ((main_reg.state == warmup_mode) ?
		(target != run_single_clock) : main_reg.s2[S2_XTEN]);
	assign cpu_clk_en = is_run(main_reg.state);
	assign wdt_clk_en = is_run(main_reg.state);
	assign wdt_low_src = is_slow(main_reg.state) ||
		((main_reg.state == run_dual_clock) && wdt_low_select);
	assign mc_low_freq = is_slow(main_reg.state);
	assign periph_clk_en = is_run(main_reg.state) || (main_reg.state == core_idle_single) ||
		(main_reg.state == core_idle_dual) || (main_reg.state == core_idle_slow);
	assign tbt_clk_en = ~frozen;
	assign core_hold = frozen;
	assign port_output_enable = ~frozen | main_reg.s1[S1_PORT_OUTPUT_HOLD_SELECT];

	// The wake pin also serves as a port bit and an interrupt input.
	assign port1_bit1_in = stop_pin_n;
	assign ext_interrupt_five_n = stop_pin_n;

endmodule

// File: common/omsc_pkg.sv
package omsc_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int CNT_W = 8;
	localparam int PC_W = 16;
	localparam int TBT_SRC_N = 4;
	localparam int TBT_SEL_W = 2;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int S1_STOP = 7;
	localparam int S1_RELEASE_MODE_SELECT = 6;
	localparam int S1_PORT_OUTPUT_HOLD_SELECT = 4;
	localparam int S2_XEN = 7;
	localparam int S2_XTEN = 6;
	localparam int S2_SYSCK = 5;
	localparam int S2_IDLE = 4;
	localparam int S2_TIMING_GEN_HALT_BIT = 2;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] S1_RST = 8'h00;
	localparam logic [7:0] S2_RST = 8'h80;
	localparam logic [PC_W-1:0] PC_STEP = 16'h0002;
	localparam logic [CNT_W-1:0] RST_WARMUP = 8'h10;
	localparam logic [1:0] LF_DIV_LAST = 2'h3;

	// ----------------------------------------
	// Operating modes
	// ----------------------------------------
	typedef enum logic [3:0] {
		run_single_clock,
		run_dual_clock,
		slow_hf_on,
		slow_hf_off,
		timebase_only_idle_fast,
		core_idle_single,
		core_idle_dual,
		timebase_only_idle_slow,
		core_idle_slow,
		stop_mode,
		warmup_mode
	} omsc_mode_type;

endpackage

// File: common/omsc_ctl_if.sv
`timescale 1ns/1ps
interface omsc_ctl_if;
	logic wake_arm;
	logic in_stop;
	logic level_mode;
	logic pin_level;
	logic mc_tick;
	logic wake_release;
	logic wu_start;
	logic wu_use_low;
	logic [omsc_pkg::CNT_W-1:0] wu_count;
	logic hf_tick;
	logic lf_tick;
	logic wu_busy;
	logic wu_done;

	modport ctl(
		output wake_arm, in_stop, level_mode, pin_level, mc_tick,
		output wu_start, wu_use_low, wu_count, hf_tick, lf_tick,
		input wake_release, wu_busy, wu_done
	);
	modport wake(
		input wake_arm, in_stop, level_mode, pin_level, mc_tick,
		output wake_release
	);
	modport warm(
		input wu_start, wu_use_low, wu_count, hf_tick, lf_tick,
		output wu_busy, wu_done
	);
endinterface

// File: hdl/omsc_wake_detect.sv
`timescale 1ns/1ps
module omsc_wake_detect
	import omsc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Control side
	omsc_ctl_if.wake ctl
);

	typedef struct packed {
		logic guard;
		logic pin_prev;
	} omsc_wake_st_type;

	localparam omsc_wake_st_type WAKE_RST = '{guard: 1'b0, pin_prev: 1'b0};

	omsc_wake_st_type wake_reg;
	omsc_wake_st_type wake_next;

	// ----------------------------------------
	// Edge guard
	// ----------------------------------------
	// The guard swallows edges for one machine cycle after stop entry, while
	// pin_prev keeps tracking so an edge in that window is consumed, not deferred.
	always_comb
	begin
		wake_next = wake_reg;
		wake_next.pin_prev = ctl.pin_level;
		if (ctl.wake_arm)
		begin
			wake_next.guard = 1'b1;
		end
		else if (ctl.mc_tick)
		begin
			wake_next.guard = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wake_reg <= WAKE_RST;
		end
		else if (clk_en)
		begin
			wake_reg <= wake_next;
		end
	end

	// Level mode releases on a high pin; edge mode on a guarded rising edge.
	// The arm strobe blocks as well, since the guard flop only rises a cycle after entry.
	assign ctl.wake_release = ctl.in_stop & (ctl.level_mode ? ctl.pin_level :
		(ctl.pin_level & ~wake_reg.pin_prev & ~wake_reg.guard & ~ctl.wake_arm));

endmodule

// File: hdl/omsc_warmup.sv
`timescale 1ns/1ps
module omsc_warmup
	import omsc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// Control side
	omsc_ctl_if.warm ctl
);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic busy;
		logic done;
	} omsc_warm_st_type;

	localparam omsc_warm_st_type WARM_RST = '{cnt: '0, busy: 1'b0, done: 1'b0};
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

	omsc_warm_st_type warm_reg;
	omsc_warm_st_type warm_next;
	logic src_tick;

	// ----------------------------------------
	// Warm-up count
	// ----------------------------------------
	assign src_tick = ctl.wu_use_low ? ctl.lf_tick : ctl.hf_tick;

	// A zero count is taken as one tick so the wait can never be skipped.
	always_comb
	begin
		warm_next = warm_reg;
		warm_next.done = 1'b0;
		if (ctl.wu_start)
		begin
			warm_next.busy = 1'b1;
			warm_next.cnt = (ctl.wu_count == '0) ? CNT_ONE : ctl.wu_count;
		end
		else if (warm_reg.busy && src_tick)
		begin
			if (warm_reg.cnt == CNT_ONE)
			begin
				warm_next.busy = 1'b0;
				warm_next.done = 1'b1;
			end
			else
			begin
				warm_next.cnt = warm_reg.cnt - CNT_ONE;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			warm_reg <= WARM_RST;
		end
		else if (clk_en)
		begin
			warm_reg <= warm_next;
		end
	end

	assign ctl.wu_busy = warm_reg.busy;
	assign ctl.wu_done = warm_reg.done;

endmodule

// File: test/omsc_wake_peer.sv
`timescale 1ns/1ps
module omsc_wake_peer
	import omsc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Pin level asked for
	input wire logic pin_high,
	// Wake pin and ticks
	output logic stop_pin_n,
	output logic high_freq_tick,
	output logic low_freq_tick,
	output logic [TBT_SRC_N-1:0] tbt_src_clocks
);
	// ------------------------------
	// Tick sources
	// ------------------------------
	// Ticks run on through stop, so oscillator start-up delay is left out of this model.
	logic [4:0] cnt_reg;
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			cnt_reg <= 5'h00;
		else
			cnt_reg <= cnt_reg + 5'h01;
	assign high_freq_tick = cnt_reg[1:0] == 2'h3;
	assign low_freq_tick = cnt_reg[2:0] == 3'h7;
	assign tbt_src_clocks = cnt_reg[4:1];
	assign stop_pin_n = pin_high;
endmodule

// File: test/omsc_chk.sv
`timescale 1ns/1ps
module omsc_chk
	import omsc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Stimulus
	input wire logic clk_en,
	input wire logic sysctl_one_wr,
	input wire logic [7:0] sysctl_one_wdata,
	input wire logic sys_reset_req,
	input wire logic stop_pin_n,
	input wire logic key_wakeup,
	input wire logic int_latch_pending,
	input wire logic [PC_W-1:0] stop_instr_pc,
	// Responses
	input wire logic [7:0] sysctl_one_rd,
	input wire omsc_mode_type op_mode,
	input wire logic [PC_W-1:0] held_pc,
	input wire logic hf_osc_en,
	input wire logic lf_osc_en,
	input wire logic cpu_clk_en,
	input wire logic tg_clear,
	input wire logic core_hold,
	input wire logic warmup_active
);
	// ------------------------------
	// Assertions
	// ------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	logic go;
	logic cmd;
	assign go = clk_en && !sys_reset_req;
	assign cmd = go && sysctl_one_wr && sysctl_one_wdata[S1_STOP] && op_mode == run_single_clock;
	a_stop_enter: assert property (cmd && !sysctl_one_wdata[S1_RELEASE_MODE_SELECT]
		|=> op_mode == stop_mode) else $error("stop not entered");
	a_level_refuse: assert property (cmd && sysctl_one_wdata[S1_RELEASE_MODE_SELECT] && stop_pin_n
		|=> op_mode == run_single_clock && !sysctl_one_rd[S1_STOP]) else $error("stop not refused");
	a_stop_quiet: assert property (op_mode == stop_mode
		|-> !hf_osc_en && !lf_osc_en && !cpu_clk_en && core_hold) else $error("stop not quiet");
	a_entry_marks: assert property (op_mode == stop_mode && $past(op_mode) != stop_mode
		|-> tg_clear && held_pc == $past(stop_instr_pc) + PC_STEP) else $error("bad stop entry");
	a_wake_now: assert property (op_mode == stop_mode && go
		&& (key_wakeup || stop_pin_n && sysctl_one_rd[S1_RELEASE_MODE_SELECT]) |=> warmup_active)
		else $error("wake missed");
	a_warm_gate: assert property (warmup_active |-> !cpu_clk_en && core_hold)
		else $error("clock open in warm-up");
	a_warm_keep: assert property (warmup_active && !stop_pin_n |=> op_mode != stop_mode)
		else $error("stop re-entered");
	a_run_clear: assert property (op_mode inside {run_single_clock, run_dual_clock, slow_hf_on,
		slow_hf_off} |-> !sysctl_one_rd[S1_STOP]) else $error("stop bit stuck");
	a_idle_wake: assert property (op_mode == core_idle_single && go && int_latch_pending
		|=> op_mode == run_single_clock) else $error("idle not released");
	c_stop: cover property (op_mode == stop_mode ##1 warmup_active);
	c_idle: cover property (op_mode == core_idle_single ##1 op_mode == run_single_clock);
	c_slow: cover property (op_mode == slow_hf_off ##1 op_mode == stop_mode);
endmodule

bind omsc_mode_ctrl omsc_chk i_omsc_chk (.core_clk, .nrst, .clk_en, .sysctl_one_wr,
	.sysctl_one_wdata, .sys_reset_req, .stop_pin_n, .key_wakeup, .int_latch_pending,
	.stop_instr_pc, .sysctl_one_rd, .op_mode, .held_pc, .hf_osc_en, .lf_osc_en, .cpu_clk_en,
	.tg_clear, .core_hold, .warmup_active);

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import omsc_pkg::*;
;
	logic core_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, pin_high = 1'b0;
	logic sysctl_one_wr = 1'b0, sysctl_two_wr = 1'b0, int_latch_pending = 1'b0;
	logic [7:0] sysctl_one_wdata = 8'h00, sysctl_two_wdata = 8'h00, warmup_count_reg = 8'h06;
	logic [1:0] timebase_source_select = 2'h0;
	logic wdt_low_select = 1'b0, key_wakeup = 1'b0, volt_detect_wake = 1'b0, sys_reset_req = 1'b0;
	logic [PC_W-1:0] stop_instr_pc = 16'hfffe;
	logic high_freq_tick, low_freq_tick, stop_pin_n, hf_osc_en, lf_osc_en, cpu_clk_en, wdt_clk_en;
	logic wdt_low_src, periph_clk_en, tbt_clk_en, mc_low_freq, tg_clear, core_hold, warmup_active;
	logic port_output_enable;
	logic [TBT_SRC_N-1:0] tbt_src_clocks;
	logic [7:0] sysctl_one_rd, sysctl_two_rd;
	logic [PC_W-1:0] held_pc;
	omsc_mode_type op_mode;
	int miscompares = 0;
	int cmp_count = 0;

	omsc_mode_ctrl #(.RESET_WARMUP(8'h02)) i_omsc_mode_ctrl (.core_clk, .nrst, .clk_en,
		.sysctl_one_wr, .sysctl_one_wdata, .sysctl_two_wr, .sysctl_two_wdata, .warmup_count_reg,
		.timebase_source_select, .wdt_low_select, .int_latch_pending, .stop_instr_pc,
		.high_freq_tick, .low_freq_tick, .tbt_src_clocks, .stop_pin_n, .key_wakeup,
		.volt_detect_wake, .sys_reset_req, .sysctl_one_rd, .sysctl_two_rd, .op_mode, .held_pc,
		.hf_osc_en, .lf_osc_en, .cpu_clk_en, .wdt_clk_en, .wdt_low_src, .periph_clk_en,
		.tbt_clk_en, .mc_low_freq, .tg_clear, .core_hold, .port_output_enable, .warmup_active,
		.port1_bit1_in(), .ext_interrupt_five_n());
	omsc_wake_peer i_omsc_wake_peer (.core_clk, .nrst, .pin_high, .stop_pin_n, .high_freq_tick,
		.low_freq_tick, .tbt_src_clocks);

	always #5 core_clk = ~core_clk;

	// ------------------------------
	// Shared tasks
	// ------------------------------
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic two, input logic [7:0] d);
		sysctl_one_wdata = d;
		sysctl_two_wdata = d;
		sysctl_one_wr = !two;
		sysctl_two_wr = two;
		cyc(1);
		sysctl_one_wr = 1'b0;
		sysctl_two_wr = 1'b0;
	endtask
	task automatic wm(input omsc_mode_type m, output int n);
		for (n = 0; n < 300 && op_mode !== m; n++)
			cyc(1);
		chk("mode", 16'(op_mode), 16'(m));
		if (op_mode !== m)
			wrap_up();
	endtask
	// Stop entry with interrupts quiet; the pc sits at the top so the held value wraps.
	task automatic enter(input logic [7:0] d);
		int_latch_pending = 1'b0;
		wr(1'b0, d);
		chk("stop", 16'({op_mode, sysctl_one_rd[S1_STOP]}), 16'({stop_mode, 1'b1}));
		chk("stop outs", 16'({hf_osc_en, lf_osc_en, cpu_clk_en, tg_clear}), 16'h1);
		chk("held pc", held_pc, stop_instr_pc + PC_STEP);
		chk("port out", 16'(port_output_enable), 16'(d[S1_PORT_OUTPUT_HOLD_SELECT]));
	endtask
	task automatic rel(input omsc_mode_type m, input int lo, input int hi);
		int n;
		for (n = 0; n < 60 && warmup_active !== 1'b1; n++)
			cyc(1);
		chk("warm", 16'(warmup_active), 16'h1);
		wm(m, n);
		chk("warm len", 16'(n >= lo && n <= hi), 16'h1);
		chk("end", 16'({sysctl_one_rd[S1_STOP], tg_clear}), 16'h1);
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_edge();
		int i;
		pin_high = 1'b0;
		for (i = 0; i < 8 && high_freq_tick !== 1'b1; i++)
			cyc(1);
		cyc(1);
		enter(8'h90);
		pin_high = 1'b1;
		cyc(8);
		chk("guard", 16'(op_mode), 16'(stop_mode));
		pin_high = 1'b0;
		cyc(2);
		pin_high = 1'b1;
		rel(run_single_clock, 16, 32);
	endtask
	task automatic t_level();
		wr(1'b0, 8'hc0);
		chk("refuse", 16'({op_mode, sysctl_one_rd[S1_STOP]}), 16'({run_single_clock, 1'b0}));
		pin_high = 1'b0;
		cyc(1);
		enter(8'hc0);
		cyc(12);
		chk("held", 16'(op_mode), 16'(stop_mode));
		pin_high = 1'b1;
		cyc(2);
		chk("level", 16'(warmup_active), 16'h1);
		pin_high = 1'b0;
		rel(run_single_clock, 14, 32);
	endtask
	task automatic t_wake();
		int k;
		for (k = 0; k < 2; k++)
		begin
			pin_high = 1'b1;
			enter(8'h80);
			cyc(12);
			chk("held", 16'(op_mode), 16'(stop_mode));
			clk_en = k != 0;
			key_wakeup = k == 0;
			volt_detect_wake = k == 1;
			cyc(3);
			chk("frozen", 16'(op_mode), 16'(k == 0 ? stop_mode : warmup_mode));
			clk_en = 1'b1;
			rel(run_single_clock, 16, 32);
			key_wakeup = 1'b0;
			volt_detect_wake = 1'b0;
		end
	endtask
	task automatic t_idle();
		int n;
		int w;
		int_latch_pending = 1'b1;
		wr(1'b1, 8'h90);
		chk("idle refuse", 16'(sysctl_two_rd), 16'h80);
		int_latch_pending = 1'b0;
		cyc(1);
		wr(1'b1, 8'h90);
		chk("idle", 16'({op_mode, cpu_clk_en, wdt_clk_en}), 16'({core_idle_single, 2'h0}));
		cyc(4);
		int_latch_pending = 1'b1;
		cyc(1);
		chk("idle exit", 16'(op_mode), 16'(run_single_clock));
		int_latch_pending = 1'b0;
		for (n = 0; n < 4; n++)
		begin
			timebase_source_select = n[1:0];
			wr(1'b1, 8'h84);
			chk("halt", 16'(op_mode), 16'(timebase_only_idle_fast));
			chk("halt gate", 16'({periph_clk_en, tbt_clk_en, cpu_clk_en}), 16'h2);
			wm(run_single_clock, w);
		end
	endtask
	task automatic t_slow();
		int n;
		wdt_low_select = 1'b1;
		wr(1'b1, 8'hc0);
		wm(run_dual_clock, n);
		chk("dual", 16'({mc_low_freq, wdt_low_src, lf_osc_en}), 16'h3);
		wr(1'b1, 8'he0);
		wm(slow_hf_on, n);
		chk("slow on", 16'({mc_low_freq, hf_osc_en}), 16'h3);
		wr(1'b1, 8'h60);
		wm(slow_hf_off, n);
		chk("slow off", 16'({mc_low_freq, hf_osc_en}), 16'h2);
		pin_high = 1'b0;
		enter(8'h80);
		cyc(40);
		pin_high = 1'b1;
		cyc(2);
		chk("hf off", 16'(hf_osc_en), 16'h0);
		rel(slow_hf_off, 36, 64);
		wr(1'b1, 8'h80);
		wm(run_single_clock, n);
	endtask
	task automatic t_sysrst();
		int n;
		pin_high = 1'b0;
		enter(8'h80);
		sys_reset_req = 1'b1;
		cyc(2);
		chk("rst mode", 16'(op_mode), 16'(warmup_mode));
		sys_reset_req = 1'b0;
		wm(run_single_clock, n);
		chk("rst regs", {sysctl_one_rd, sysctl_two_rd}, {S1_RST, S2_RST});
	endtask

	initial
	begin
		int n;
		cyc(3);
		nrst = 1'b1;
		wm(run_single_clock, n);
		t_edge();
		t_level();
		t_wake();
		t_idle();
		t_slow();
		t_sysrst();
		wrap_up();
	end
endmodule
